// ---- design/spdif_src_ctrl.sv ----
// Purpose: Serial audio source driving an S/PDIF transmitter input stage
// Assumes: User pushes left-aligned 24-bit stereo pairs on clk
// Notes:   Bit clock and oversampling clock are divided from clk
// Functional notes
// - Formats left-justified, I2S, right-justified selectable; I2S is default.
// - Word widths 16, 18, 20 or 24 bits, sent at configured width.
// - Right-justified: frame sync high marks left word, low marks right.
// - Right-justified MSB starts 12 bits (20-bit) or 16 bits (16-bit) after edge.
// - Frame is 64 bit clocks; LSB ends on next frame sync edge.
// - I2S: frame sync low marks left word, high marks right.
// - I2S: MSB appears one bit clock after each frame sync edge.
// - Left-justified: frame sync high marks left word, low marks right.
// - Left-justified: MSB in first bit clock after edge, no delay.
// - Oversampling clock 256 or 384 times frame rate; frame rate max 192 kHz.
`timescale 1ns/1ps
`include "spdif_src_regs.svh"
module spdif_src_ctrl
   import spdif_src_pkg::*;
#(
   parameter int HALF_BIT = `SRC_HALF_BIT_DEF
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 enable,
   input  wire spdif_src_pkg::fmt_t  fmt,
   input  wire spdif_src_pkg::wsel_t wsel,
   input  wire logic                 ratio_384,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   input  wire spdif_src_pkg::pair_t in_pair,
   output spdif_src_pkg::audio_pins_t pins,
   output logic                      underrun
);
   import spdif_src_pkg::*;

   localparam int BIT_NS   = 2 * HALF_BIT * `SRC_CLK_PERIOD_NS;
   localparam int FRAME_NS = BIT_NS * `SRC_BITS_PER_FRAME;

   initial begin
      if (HALF_BIT % `SRC_OS_DIV_256 != 0 || HALF_BIT % `SRC_OS_DIV_384 != 0
          || HALF_BIT >= (1 << `SRC_DIV_W))
         $error("HALF_BIT must be a multiple of 12 below 256");
      if (BIT_NS < `SRC_MIN_BIT_PERIOD_NS) $error("Bit clock too fast");
      if (64'(FRAME_NS) * `SRC_MAX_FRAME_HZ < 64'(`SRC_NS_PER_S)) $error("Frame rate too high");
   end

   localparam logic [`SRC_DIV_W-1:0] HB_LAST = `SRC_DIV_W'(HALF_BIT - 1);
   localparam logic [`SRC_DIV_W-1:0] OS_L256 = `SRC_DIV_W'(HALF_BIT / `SRC_OS_DIV_256 - 1);
   localparam logic [`SRC_DIV_W-1:0] OS_L384 = `SRC_DIV_W'(HALF_BIT / `SRC_OS_DIV_384 - 1);

   typedef struct packed {
      state_t                st;
      logic [`SRC_DIV_W-1:0] div;
      logic                  bclk;
      logic [5:0]            idx;
      logic                  fs;
      logic                  sd;
      logic [`SRC_DIV_W-1:0] os_div;
      logic                  osc;
      logic                  r384;
      pair_t                 pair;
      fmt_t                  fmt;
      wsel_t                 wsel;
      logic                  underrun;
   } ctrl_state_t;

   ctrl_state_t s_q;
   ctrl_state_t s_d;
   logic        f_valid;
   pair_t       f_pair;
   logic        pop;
   logic        fall;
   logic [5:0]  nidx;

   function automatic logic [5:0] width_of(input wsel_t w);
      case (w)
         W16:     width_of = 6'h10;
         W18:     width_of = 6'h12;
         W20:     width_of = 6'h14;
         W24:     width_of = 6'h18;
         default: width_of = 6'h18;
      endcase
   endfunction

   // Level of frame sync for a given half of the frame
   function automatic logic fs_level(input fmt_t f, input logic right_half);
      fs_level = (f == FMT_I2S) ? right_half : !right_half;
   endfunction

   // Serial bit for a frame position
   function automatic logic bit_at(input fmt_t f, input wsel_t w, input pair_t p,
                                   input logic [5:0] i);
      logic [5:0]  start;
      logic [5:0]  k;
      logic [23:0] word;
      start = `SRC_LJ_DELAY;
      if (f == FMT_I2S) start = `SRC_I2S_DELAY;
      if (f == FMT_RJ) start = 6'(`SRC_SLOT_BITS) - width_of(w);
      word = i[5] ? p.right : p.left;
      k = {1'b0, i[4:0]} - start;
      bit_at = 1'b0;
      if ({1'b0, i[4:0]} >= start && k < width_of(w)) bit_at = word[5'(`SRC_WORD_MSB) - k[4:0]];
   endfunction

   sample_fifo #(
      .W     (2 * `SRC_WORD_BITS),
      .DEPTH (`SRC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_pair),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_pair)
   );

   assign fall = (s_q.st == ST_RUN) && s_q.bclk && (s_q.div == HB_LAST);
   assign nidx = s_q.idx + 6'h01;
   assign pop  = fall && (nidx == 6'h00) && enable && f_valid;

   always_comb begin
      s_d = s_q;
      // Oversampling clock divider, ratio fixed per frame
      if (s_q.os_div == (s_q.r384 ? OS_L384 : OS_L256)) begin
         s_d.os_div = '0;
         s_d.osc    = !s_q.osc;
      end else begin
         s_d.os_div = s_q.os_div + 1'b1;
      end
      case (s_q.st)
         ST_IDLE: begin
            s_d.bclk = 1'b0;
            s_d.sd   = 1'b0;
            s_d.fmt  = fmt;
            s_d.wsel = wsel;
            s_d.r384 = ratio_384;
            s_d.fs   = fs_level(fmt, 1'b1);
            if (enable) begin
               s_d.st   = ST_RUN;
               s_d.bclk = 1'b1;
               s_d.div  = '0;
               s_d.idx  = `SRC_IDX_LAST;
            end
         end
         ST_RUN: begin
            if (s_q.div == HB_LAST) begin
               s_d.div  = '0;
               s_d.bclk = !s_q.bclk;
            end else begin
               s_d.div = s_q.div + 1'b1;
            end
            if (fall) begin
               s_d.idx = nidx;
               if (nidx == 6'h00) begin
                  s_d.fmt      = fmt;
                  s_d.wsel     = wsel;
                  s_d.r384     = ratio_384;
                  s_d.pair     = f_valid ? f_pair : '0;
                  s_d.underrun = !f_valid;
                  if (!enable) begin
                     s_d.st  = ST_IDLE;
                     s_d.sd  = 1'b0;
                  end
               end
               s_d.fs = fs_level(s_d.fmt, nidx[5]);
               if (s_d.st == ST_RUN) s_d.sd = bit_at(s_d.fmt, s_d.wsel, s_d.pair, nidx);
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
      // Divider restarts on ratio change, count stays in range
      if (s_d.r384 != s_q.r384) s_d.os_div = '0;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: ST_IDLE, div: '0, bclk: 1'b0, idx: '0, fs: 1'b1, sd: 1'b0,
                  os_div: '0, osc: 1'b0, r384: 1'b0, pair: '0, fmt: FMT_I2S,
                  wsel: W24, underrun: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign pins     = '{bit_clock: s_q.bclk, frame_sync: s_q.fs,
                       serial_sample_line: s_q.sd, oversampling_clock: s_q.osc};
   assign underrun = s_q.underrun;

   // Checks
   logic        run;
   logic [23:0] cur;
   assign run = (s_q.st == ST_RUN);
   assign cur = s_q.idx[5] ? s_q.pair.right : s_q.pair.left;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence frame_start_s;
      fall && (nidx == 6'h00);
   endsequence

   fmt_frame_hold_a: assert property (run && $past(run) && $changed(s_q.fmt)
                                      |-> s_q.idx == 6'h00)
      else $error("format changed mid frame");
   width_zero_pad_a: assert property (run && s_q.fmt == FMT_LJ && s_q.wsel == W16
                                      && s_q.idx[4:0] >= 5'h10 |-> !s_q.sd)
      else $error("data beyond word width");
   data_rise_stable_a: assert property ($changed(s_q.sd) |-> !s_q.bclk)
      else $error("data moved on rising edge");
   rj_fs_level_a: assert property (run && s_q.fmt == FMT_RJ |-> s_q.fs == !s_q.idx[5])
      else $error("right-justified frame sync wrong");
   rj_msb_pos_a: assert property (run && s_q.fmt == FMT_RJ && s_q.wsel == W20
                                  && s_q.idx[4:0] == 5'h0c |-> s_q.sd == cur[23])
      else $error("right-justified MSB misplaced");
   frame_len_a: assert property (fall && s_q.idx == `SRC_IDX_LAST |-> ##1 s_q.idx == 6'h00)
      else $error("frame length wrong");
   i2s_fs_level_a: assert property (run && s_q.fmt == FMT_I2S |-> s_q.fs == s_q.idx[5])
      else $error("I2S frame sync wrong");
   i2s_msb_delay_a: assert property (run && s_q.fmt == FMT_I2S && s_q.idx[4:0] == 5'h01
                                     |-> s_q.sd == cur[23])
      else $error("I2S MSB not one bit late");
   lj_fs_level_a: assert property (run && s_q.fmt == FMT_LJ |-> s_q.fs == !s_q.idx[5])
      else $error("left-justified frame sync wrong");
   lj_msb_first_a: assert property (run && s_q.fmt == FMT_LJ && s_q.idx[4:0] == 5'h00
                                    |-> s_q.sd == cur[23])
      else $error("left-justified MSB delayed");
   os_div_range_a: assert property (s_q.os_div <= (s_q.r384 ? OS_L384 : OS_L256))
      else $error("oversampling divider overrun");
   os_toggle_a: assert property (s_q.r384 && $changed(s_q.osc) && $stable(s_q.r384)
                                 |-> ##1 $stable(s_q.osc))
      else $error("oversampling half period wrong");
   os_half_256_a: assert property (!s_q.r384 && $changed(s_q.osc) && $stable(s_q.r384)
                                   |-> ##1 $stable(s_q.osc) ##1 $stable(s_q.osc))
      else $error("oversampling half period short");
   pair_pop_a: assert property (pop |-> frame_start_s)
      else $error("pair taken off frame start");

endmodule // spdif_src_ctrl

// ---- design/spdif_src_regs.svh ----
// Purpose: Named constants for the serial audio source controller
// Assumes: 125 MHz system clock
// Notes:   Definitions only
`ifndef SPDIF_SRC_REGS_SVH
`define SPDIF_SRC_REGS_SVH

`define SRC_CLK_PERIOD_NS     8
`define SRC_MIN_BIT_PERIOD_NS 80
`define SRC_MAX_FRAME_HZ      192000
`define SRC_BITS_PER_FRAME    64
`define SRC_IDX_LAST          6'h3f
`define SRC_SLOT_BITS         32
`define SRC_WORD_BITS         24
`define SRC_WORD_MSB          23
`define SRC_FIFO_DEPTH        16
`define SRC_HALF_BIT_DEF      12
`define SRC_DIV_W             8
`define SRC_I2S_DELAY         6'h01
`define SRC_LJ_DELAY          6'h00
`define SRC_OS_DIV_256        4
`define SRC_OS_DIV_384        6
`define SRC_NS_PER_S          1000000000

`endif

// ---- design/spdif_src_pkg.sv ----
// Purpose: Types for the serial audio source controller
// Assumes: Constants come from spdif_src_regs.svh
// Notes:   Format default is I2S (code zero)
package spdif_src_pkg;

   typedef enum logic [1:0] {
      FMT_I2S = 2'h0,
      FMT_LJ  = 2'h1,
      FMT_RJ  = 2'h2
   } fmt_t;

   typedef enum logic [1:0] {
      W16 = 2'h0,
      W18 = 2'h1,
      W20 = 2'h2,
      W24 = 2'h3
   } wsel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } state_t;

   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } pair_t;

   typedef struct packed {
      logic bit_clock;
      logic frame_sync;
      logic serial_sample_line;
      logic oversampling_clock;
   } audio_pins_t;

endpackage

// ---- design/sample_fifo.sv ----
// Purpose: Stereo pair FIFO between user port and serialiser
// Assumes: Single clock, pop only when out_valid
// Notes:   in_ready is a registered not-full flag
`timescale 1ns/1ps
`include "spdif_src_regs.svh"
module sample_fifo #(
   parameter int W     = 48,
   parameter int DEPTH = `SRC_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          rdy;
   } fifo_state_t;

   fifo_state_t  s_q;
   fifo_state_t  s_d;
   logic [W-1:0] mem [DEPTH];
   logic         push;
   logic         pop;

   assign push      = in_valid && s_q.rdy;
   assign pop       = out_ready && (s_q.cnt != '0);
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = mem[s_q.rp];
   assign in_ready  = s_q.rdy;

   always_comb begin
      s_d = s_q;
      if (push) s_d.wp = s_q.wp + 1'b1;
      if (pop) s_d.rp = s_q.rp + 1'b1;
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem[s_q.wp] <= in_data;
   end

endmodule // sample_fifo

// ---- dv/spdif_rx_model.sv ----
// Purpose: Receiving stage of the S/PDIF transmitter, behavioural
// Assumes: Format, width and ratio match the source's settings
// Notes:   Decodes pairs and counts oversampling clocks per frame
`timescale 1ns/1ps
module spdif_rx_model
   import spdif_src_pkg::*;
(
   input  wire spdif_src_pkg::audio_pins_t pins,
   input  wire spdif_src_pkg::fmt_t        fmt,
   input  wire spdif_src_pkg::wsel_t       wsel,
   input  wire logic                       ratio_384,
   output spdif_src_pkg::pair_t            pair,
   output int                              n_pair,
   output int                              n_osc
);
   logic [23:0] left_w, word;
   logic        fs_prev, left_lvl, bip_clk;
   int          slot, first, width, osc_cnt, div_cnt;
   initial begin
      n_pair = 0;
      n_osc = 0;
      osc_cnt = 0;
      div_cnt = 0;
      slot = 0;
      bip_clk = 1'b0;
      fs_prev = 1'bx;
      word = '0;
      left_w = '0;
      pair = '0;
   end
   // Slot count restarts at each frame sync change
   always @(posedge pins.bit_clock) begin
      width = (wsel == W16) ? 16 : (wsel == W18) ? 18 : (wsel == W20) ? 20 : 24;
      first = (fmt == FMT_I2S) ? 1 : (fmt == FMT_LJ) ? 0 : 32 - width;
      left_lvl = (fmt != FMT_I2S);
      if (pins.frame_sync !== fs_prev) begin
         slot = 0;
         word = '0;
      end
      if (slot >= first && slot < first + width)
         word = {word[22:0], pins.serial_sample_line};
      slot++;
      fs_prev = pins.frame_sync;
      if (slot == 32) begin
         word = word << (24 - width);
         if (fs_prev == left_lvl)
            left_w = word;
         else begin
            pair = {left_w, word};
            n_pair++;
         end
      end
   end
   // Biphase clock divided from oversampling clock
   always @(posedge pins.oversampling_clock) begin
      osc_cnt++;
      div_cnt = (div_cnt + 1) % (ratio_384 ? 3 : 2);
      bip_clk = (div_cnt == 0);
   end
   always @(pins.frame_sync) begin
      if (pins.frame_sync == (fmt != FMT_I2S)) begin
         n_osc = osc_cnt;
         osc_cnt = 0;
      end
   end
endmodule // spdif_rx_model

// ---- dv/spdif_src_ctrl_test.sv ----
// Purpose: Self-checking bench for the serial audio source controller
// Assumes: HALF_BIT of 12, the smallest that serves both ratios
// Notes:   Pairs are decoded by the receiving model
`timescale 1ns/1ps
module spdif_src_ctrl_test;
   import spdif_src_pkg::*;
   logic        clk, rst_b, enable, ratio_384, in_valid, in_ready, underrun;
   fmt_t        fmt;
   wsel_t       wsel;
   pair_t       in_pair, rx_pair;
   audio_pins_t pins;
   int          n_mismatch, checked, n_pair, n_osc, base;
   spdif_src_ctrl #(.HALF_BIT(12)) dut (.clk(clk), .rst_b(rst_b), .enable(enable), .fmt(fmt),
      .wsel(wsel), .ratio_384(ratio_384), .in_valid(in_valid), .in_ready(in_ready),
      .in_pair(in_pair), .pins(pins), .underrun(underrun));
   spdif_rx_model partner (.pins(pins), .fmt(fmt), .wsel(wsel), .ratio_384(ratio_384),
      .pair(rx_pair), .n_pair(n_pair), .n_osc(n_osc));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic pair_t pat(input int i);
      logic [23:0] l;
      l = 24'h9ab3c5 + 24'h010101 * i[23:0];
      return {l, ~l};
   endfunction
   // Holds valid and data until a cycle with ready high
   task automatic push(input pair_t p);
      in_valid = 1'b1;
      in_pair = p;
      while (in_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
   endtask
   // Pushes np pairs, runs nf frames, checks each decoded pair
   task automatic run(input fmt_t f, input wsel_t w, input logic r, input int np, input int nf);
      logic [23:0] m;
      int          t;
      m = 24'hffffff << (8 - 2 * int'(w) - (w == W24 ? 2 : 0));
      fmt = f;
      wsel = w;
      ratio_384 = r;
      base = n_pair;
      for (int i = 0; i < np; i++) push(pat(i));
      if (np == 16) begin
         in_pair = pat(16);
         repeat (2) @(posedge clk) #1;
         cmp(in_ready, 0);
      end
      in_valid = 1'b0;
      enable = 1'b1;
      for (int i = 0; i < nf; i++) begin
         t = 0;
         while (n_pair < base + i + 1 && t < 2000) begin
            @(posedge clk);
            t++;
         end
         if (t >= 2000) n_mismatch++;
         #1;
         cmp(rx_pair, i < np ? pat(i) & {m, m} : '0);
         cmp(underrun, i >= np);
      end
      enable = 1'b0;
      repeat (100) @(posedge clk);
      #1;
      cmp(pins.bit_clock, 0);
      cmp(n_osc, r ? 384 : 256);
   endtask
   initial begin
      n_mismatch = 0;
      checked = 0;
      rst_b = 1'b0;
      enable = 1'b0;
      fmt = FMT_I2S;
      wsel = W24;
      ratio_384 = 1'b0;
      in_valid = 1'b0;
      in_pair = '0;
      repeat (5) @(posedge clk);
      #1;
      cmp(pins, 4'b0100);
      cmp({in_ready, underrun}, 2'b10);
      rst_b = 1'b1;
      run(FMT_I2S, W24, 1'b1, 16, 17);
      for (int f = 0; f < 3; f++)
         for (int w = 0; w < 4; w++)
            run(fmt_t'(f), wsel_t'(w), w[0], 2, 3);
      end_sim();
   end
   initial begin
      #760000;
      n_mismatch++;
      end_sim();
   end
endmodule // spdif_src_ctrl_test
